// >>> core/jtap_fifo.sv
`timescale 1ns/1ns
module jtap_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic clk, // fifo clock
    input wire logic rst_b, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // space left
    input wire logic [W-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // reader takes word
    output logic [W-1:0] out_data // head word
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic [AW:0] wr_d;
    logic [AW:0] rd_d;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // extra pointer bit tells full from empty without a counter
    assign in_ready = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    assign out_valid = (wr_q != rd_q);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign wr_d = push ? wr_q + (AW+1)'(1) : wr_q;
    assign rd_d = pop ? rd_q + (AW+1)'(1) : rd_q;
    assign out_data = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

endmodule

// >>> core/jtap_pkg.sv
// Notes on behaviour
// [R1] test reset low forces and holds reset state
// [R2] power-on reset also forces reset state
// [R3] reset state loads identification instruction
// [R4] mode select sampled each rising test clock
// [R5] five high mode samples reach reset state
// [R6] data input shifted into selected chain
// [R7] host changes inputs on falling test clock
// [R8] data output changes on falling test clock
// [R9] data output driven only while shifting
// [R10] stopped test clock keeps all state
// [R11] four-bit instruction chain holds current instruction
// [R12] state picks chain, capture, shift, update
// [R13] held instruction selects the data chain
// [R14] chains capture, shift, then update parallel register
// [R15] unknown instructions decode as bypass
// [R16] external and internal test touch no boundary chain, shift through bypass
// [R17] output mux picks core or local chain
// [R18] full sixteen-state test access graph
package jtap_pkg;

    localparam int IRW = 4;
    localparam int IDW = 32;
    localparam int DW_DEF = 8;
    localparam int BSW_DEF = 8;
    localparam int FIFO_DEPTH = 16;

    localparam logic [IRW-1:0] I_EXTEST = 4'h0;
    localparam logic [IRW-1:0] I_INTEST = 4'h1;
    localparam logic [IRW-1:0] I_SAMPLE = 4'h2;
    localparam logic [IRW-1:0] I_USER = 4'h4;
    localparam logic [IRW-1:0] I_ABORT = 4'h8;
    localparam logic [IRW-1:0] I_DPACC = 4'hA;
    localparam logic [IRW-1:0] I_APACC = 4'hB;
    localparam logic [IRW-1:0] I_IDCODE = 4'hE;
    localparam logic [IRW-1:0] I_BYPASS = 4'hF;

    // instruction chain capture pattern, low bits fixed at 01
    localparam logic [IRW-1:0] IR_CAPT = 4'h1;
    // identification value is arbitrary; bit 0 must stay set
    localparam logic [IDW-1:0] ID_DEF = 32'h0000_0001;
    localparam logic BYP_CAPT = 1'h0;
    localparam logic [2:0] TMS_RST_RUN = 3'h5;

    typedef enum logic [3:0] {
        S_TLR = 4'h0,
        S_RTI = 4'h1,
        S_SDR = 4'h3,
        S_CDR = 4'h2,
        S_SHDR = 4'h6,
        S_E1DR = 4'h7,
        S_PDR = 4'h5,
        S_E2DR = 4'h4,
        S_UDR = 4'hC,
        S_SIR = 4'hD,
        S_CIR = 4'hF,
        S_SHIR = 4'hE,
        S_E1IR = 4'hA,
        S_PIR = 4'hB,
        S_E2IR = 4'h9,
        S_UIR = 4'h8
    } jtap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } jtap_pin_t;

    typedef struct packed {
        logic tdo;
        logic oe;
    } jtap_tdo_t;

endpackage

// >>> core/jtap_tap.sv
`timescale 1ns/1ns
module jtap_tap #(
    parameter int DW = jtap_pkg::DW_DEF,
    parameter int BSW = jtap_pkg::BSW_DEF,
    parameter int FDEPTH = jtap_pkg::FIFO_DEPTH,
    parameter logic [31:0] ID_VAL = jtap_pkg::ID_DEF
) (
    input wire logic ref_clk, // system clock, 50 MHz
    input wire logic rst_b, // power-on reset, async, active low
    input wire logic trst_b, // test reset pin, async, active low
    input wire jtap_pkg::jtap_pin_t pins_i, // test clock, mode select, data in
    output jtap_pkg::jtap_tdo_t tdo_o, // serial out and its enable
    input wire logic core_tdo_i, // serial out of the core debug port
    output logic core_sel_o, // core debug instruction in force
    input wire logic [BSW-1:0] bs_pad_i, // pad levels seen by boundary cells
    output logic [BSW-1:0] bs_pad_o, // boundary update register
    output logic ext_mode_o, // external test in force
    output logic int_mode_o, // internal test in force
    output logic [DW-1:0] usr_data_o, // word from user data chain
    output logic usr_valid_o, // word available
    input wire logic usr_ready_i // user logic takes word
);
    import jtap_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // reset: async assert, release two edges later
    logic arst_b;
    logic [1:0] trs_q;
    logic tap_rst_n;

    assign arst_b = rst_b & trst_b;

    always_ff @(posedge ref_clk or negedge arst_b)
    begin
        if (!arst_b)
        begin
            trs_q <= 2'h0; // [R1] [R2]
        end
        else
        begin
            trs_q <= {trs_q[0], 1'h1};
        end
    end

    assign tap_rst_n = trs_q[1];

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the host moves pins on the falling test clock,
    // so half a test clock period of settling is assumed
    jtap_pin_t pin_s1_q;
    jtap_pin_t pin_s2_q;
    logic tck_s3_q;
    logic core_s1_q;
    logic core_s2_q;
    logic [BSW-1:0] bs_s1_q;
    logic [BSW-1:0] bs_s2_q;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // pins idle at their pull-up level; a low reset value here would
            // fake a test clock rise just after reset lets go
            pin_s1_q <= '1;
            pin_s2_q <= '1;
            tck_s3_q <= 1'h1;
            core_s1_q <= 1'h0;
            core_s2_q <= 1'h0;
            bs_s1_q <= '0;
            bs_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= pins_i; // [R7]
            pin_s2_q <= pin_s1_q;
            tck_s3_q <= pin_s2_q.tck;
            core_s1_q <= core_tdo_i;
            core_s2_q <= core_s1_q;
            bs_s1_q <= bs_pad_i;
            bs_s2_q <= bs_s1_q;
        end
    end

    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;

    // no edge seen means nothing below moves except the queue's system-side read port
    assign tck_rise = pin_s2_q.tck & ~tck_s3_q; // [R10]
    assign tck_fall = ~pin_s2_q.tck & tck_s3_q;
    assign tms = pin_s2_q.tms;
    assign tdi = pin_s2_q.tdi;

    ////////////////////////////////////////////////////////////////////////
    // test access state machine
    jtap_state_t state_q;
    jtap_state_t state_d;
    jtap_state_t state_nx;

    always_comb
    begin
        case (state_q) // [R18] [R5]
            S_TLR: state_d = tms ? S_TLR : S_RTI;
            S_RTI: state_d = tms ? S_SDR : S_RTI;
            S_SDR: state_d = tms ? S_SIR : S_CDR;
            S_CDR: state_d = tms ? S_E1DR : S_SHDR;
            S_SHDR: state_d = tms ? S_E1DR : S_SHDR;
            S_E1DR: state_d = tms ? S_UDR : S_PDR;
            S_PDR: state_d = tms ? S_E2DR : S_PDR;
            S_E2DR: state_d = tms ? S_UDR : S_SHDR;
            S_UDR: state_d = tms ? S_SDR : S_RTI;
            S_SIR: state_d = tms ? S_TLR : S_CIR;
            S_CIR: state_d = tms ? S_E1IR : S_SHIR;
            S_SHIR: state_d = tms ? S_E1IR : S_SHIR;
            S_E1IR: state_d = tms ? S_UIR : S_PIR;
            S_PIR: state_d = tms ? S_E2IR : S_PIR;
            S_E2IR: state_d = tms ? S_UIR : S_SHIR;
            S_UIR: state_d = tms ? S_SDR : S_RTI;
            default: state_d = S_TLR;
        endcase
    end

    assign state_nx = tck_rise ? state_d : state_q; // [R4]

    always_ff @(posedge ref_clk or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            state_q <= S_TLR; // [R1] [R2]
        end
        else
        begin
            state_q <= state_nx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state and instruction decode
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;
    logic [IRW-1:0] ir_q;
    logic is_core;
    logic is_id;
    logic is_bs;
    logic is_usr;
    logic is_byp;

    assign cap_ir = tck_rise && (state_q == S_CIR); // [R12]
    assign sh_ir = tck_rise && (state_q == S_SHIR);
    assign upd_ir = tck_rise && (state_q == S_UIR);
    assign cap_dr = tck_rise && (state_q == S_CDR);
    assign sh_dr = tck_rise && (state_q == S_SHDR);
    assign upd_dr = tck_rise && (state_q == S_UDR);

    assign is_core = (ir_q == I_ABORT) || (ir_q == I_DPACC) || (ir_q == I_APACC); // [R13]
    assign is_id = (ir_q == I_IDCODE);
    assign is_bs = (ir_q == I_SAMPLE);
    assign is_usr = (ir_q == I_USER);
    // external/internal test and any unknown code fall through to bypass
    assign is_byp = !(is_core || is_id || is_bs || is_usr); // [R15] [R16]

    assign core_sel_o = is_core; // [R17]
    assign ext_mode_o = (ir_q == I_EXTEST); // [R16]
    assign int_mode_o = (ir_q == I_INTEST);

    ////////////////////////////////////////////////////////////////////////
    // shift chains and parallel registers
    logic [IRW-1:0] ir_sh_q;
    logic [IRW-1:0] ir_sh_d;
    logic [IRW-1:0] ir_d;
    logic byp_q;
    logic byp_d;
    logic [IDW-1:0] id_sh_q;
    logic [IDW-1:0] id_sh_d;
    logic [BSW-1:0] bs_sh_q;
    logic [BSW-1:0] bs_sh_d;
    logic [BSW-1:0] bs_upd_q;
    logic [BSW-1:0] bs_upd_d;
    logic [DW-1:0] usr_sh_q;
    logic [DW-1:0] usr_sh_d;
    logic push_rdy;
    logic push_v;

    assign ir_sh_d = cap_ir ? IR_CAPT : sh_ir ? {tdi, ir_sh_q[IRW-1:1]} : ir_sh_q; // [R6] [R11]
    assign ir_d = (state_q == S_TLR) ? I_IDCODE : upd_ir ? ir_sh_q : ir_q; // [R3] [R14]
    assign byp_d = (cap_dr && is_byp) ? BYP_CAPT : (sh_dr && is_byp) ? tdi : byp_q;
    assign id_sh_d = (cap_dr && is_id) ? ID_VAL :
        (sh_dr && is_id) ? {tdi, id_sh_q[IDW-1:1]} : id_sh_q;
    assign bs_sh_d = (cap_dr && is_bs) ? bs_s2_q :
        (sh_dr && is_bs) ? {tdi, bs_sh_q[BSW-1:1]} : bs_sh_q; // [R14]
    assign bs_upd_d = (upd_dr && is_bs) ? bs_sh_q : bs_upd_q;
    // capture shows whether the buffer can take the next update
    assign usr_sh_d = (cap_dr && is_usr) ? {{(DW-1){1'h0}}, push_rdy} :
        (sh_dr && is_usr) ? {tdi, usr_sh_q[DW-1:1]} : usr_sh_q;
    assign push_v = upd_dr && is_usr;

    always_ff @(posedge ref_clk or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            ir_sh_q <= IR_CAPT;
            ir_q <= I_IDCODE; // [R3]
        end
        else
        begin
            ir_sh_q <= ir_sh_d;
            ir_q <= ir_d;
        end
    end

    // data chains ride out a test reset untouched, only power-on clears them
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            byp_q <= BYP_CAPT;
            id_sh_q <= '0;
            bs_sh_q <= '0;
            bs_upd_q <= '0;
            usr_sh_q <= '0;
        end
        else
        begin
            byp_q <= byp_d;
            id_sh_q <= id_sh_d;
            bs_sh_q <= bs_sh_d;
            bs_upd_q <= bs_upd_d;
            usr_sh_q <= usr_sh_d;
        end
    end

    assign bs_pad_o = bs_upd_q;

    ////////////////////////////////////////////////////////////////////////
    // user words queue for the system side; a word updated while the
    // queue is full is dropped, the host sees that in the captured bit
    jtap_fifo #(
        .W(DW),
        .D(FDEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_b(rst_b),
        .in_valid(push_v),
        .in_ready(push_rdy),
        .in_data(usr_sh_q),
        .out_valid(usr_valid_o),
        .out_ready(usr_ready_i),
        .out_data(usr_data_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // serial output, moved only on the falling test clock
    logic tdo_mux;
    logic shifting;
    logic tdo_q;
    logic oe_q;

    assign shifting = (state_q == S_SHIR) || (state_q == S_SHDR); // [R9]
    assign tdo_mux = (state_q == S_SHIR) ? ir_sh_q[0] :
        is_core ? core_s2_q :
        is_id ? id_sh_q[0] :
        is_bs ? bs_sh_q[0] :
        is_usr ? usr_sh_q[0] : byp_q; // [R17]

    always_ff @(posedge ref_clk or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            tdo_q <= 1'h0;
            oe_q <= 1'h0;
        end
        else
        begin
            tdo_q <= tck_fall ? tdo_mux : tdo_q; // [R8]
            oe_q <= tck_fall ? shifting : oe_q; // [R9]
        end
    end

    assign tdo_o.tdo = tdo_q;
    assign tdo_o.oe = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [2:0] tms_run_q;
    logic [2:0] tms_run_d;

    assign tms_run_d = !tck_rise ? tms_run_q : !tms ? 3'h0 :
        (tms_run_q == TMS_RST_RUN) ? tms_run_q : 3'(tms_run_q + 3'h1);

    always_ff @(posedge ref_clk or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            tms_run_q <= 3'h0;
        end
        else
        begin
            tms_run_q <= tms_run_d;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!tap_rst_n);

    sequence s_rti_tms_high;
        tck_rise && (state_q == S_RTI) && tms;
    endsequence

    sequence s_enter_sdr;
        state_q == S_SDR;
    endsequence

    a_trst_force: // [R1]
    assert property (@(posedge ref_clk) disable iff (!rst_b)
        !trst_b |-> state_q == S_TLR)
    else $error("test reset did not hold reset state");

    a_por_state: // [R2]
    assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(tap_rst_n) |-> state_q == S_TLR && ir_q == I_IDCODE)
    else $error("reset state missing after power-on reset");

    a_tlr_idcode: // [R3]
    assert property (state_q == S_TLR |=> ir_q == I_IDCODE)
    else $error("identification instruction not loaded in reset state");

    a_tms_step: // [R4]
    assert property (s_rti_tms_high |=> s_enter_sdr)
    else $error("mode select step from idle went wrong");

    a_five_tms: // [R5]
    assert property (tms_run_q == TMS_RST_RUN |-> state_q == S_TLR)
    else $error("five high mode samples did not reach reset state");

    a_ir_shift_in: // [R6]
    assert property (sh_ir |=> ir_sh_q[IRW-1] == $past(tdi))
    else $error("data input not shifted into instruction chain");

    a_tdo_fall_edge: // [R8]
    assert property ($changed(tdo_q) || $changed(oe_q) |-> $past(tck_fall))
    else $error("serial output moved away from falling test clock");

    a_tdo_oe_shift: // [R9]
    assert property (tck_fall |=> oe_q == $past(shifting))
    else $error("serial output enable wrong for state");

    a_clock_stop: // [R10]
    assert property (!tck_rise |=> $stable(state_q) && $stable(bs_upd_q))
    else $error("state changed without a test clock rise");

    a_ir_update: // [R11]
    assert property (upd_ir |=> ir_q == $past(ir_sh_q))
    else $error("instruction not taken in update state");

    a_ir_capture: // [R12]
    assert property (cap_ir |=> ir_sh_q == IR_CAPT)
    else $error("instruction chain capture pattern wrong");

    a_id_capture: // [R13]
    assert property (cap_dr && is_id |=> id_sh_q == ID_VAL)
    else $error("identification chain not captured");

    a_bs_update: // [R14]
    assert property (upd_dr && is_bs |=> bs_upd_q == $past(bs_sh_q))
    else $error("boundary update register not loaded");

    a_unknown_bypass: // [R15]
    assert property (cap_dr && ir_q == 4'h3 |=> byp_q == BYP_CAPT)
    else $error("unknown instruction did not select bypass");

    a_test_no_chain: // [R16]
    assert property (ext_mode_o || int_mode_o |=> $stable(bs_sh_q) && $stable(bs_upd_q))
    else $error("test instruction moved the boundary chain");

    a_core_mux: // [R17]
    assert property (tck_fall && is_core && state_q == S_SHDR |=> tdo_q == $past(core_s2_q))
    else $error("core serial output not selected");

    a_ir_exit_path: // [R18]
    assert property (tck_rise && state_q == S_E1IR && !tms |=> state_q == S_PIR)
    else $error("instruction exit did not reach pause");

endmodule

// >>> testbench/jtap_host.sv
`timescale 1ns/1ns
module jtap_host (
    output jtap_pkg::jtap_pin_t pins, // test clock, mode select, data in
    input wire jtap_pkg::jtap_tdo_t line // serial out and its enable
);
    import jtap_pkg::*;
    int edge_err = 0;
    logic oe_all = 1'b1;
    // tck stands still high between frames, as its pull-up leaves it
    initial pins = 3'b111;
    ////////////////////////////////////////////////////////////////
    // tdo is read late in the high phase: the block answers 2-3 ref_clk after the fall
    task automatic clk1(input logic m, input logic d, output logic o);
        logic early;
        pins.tck = 1'b0;
        pins.tms = m;
        pins.tdi = d;
        #80;
        pins.tck = 1'b1;
        #20;
        // a released line floats to its pull-up level
        early = line.oe ? line.tdo : 1'b1;
        #60;
        o = line.oe ? line.tdo : 1'b1;
        if (early !== o)
            edge_err++;
    endtask
    task automatic to_idle(input int n);
        logic o;
        repeat (n) clk1(1'b1, 1'b1, o);
        clk1(1'b0, 1'b1, o);
    endtask
    task automatic goto_shift(input logic ir);
        logic o;
        clk1(1'b1, 1'b1, o);
        if (ir)
            clk1(1'b1, 1'b1, o);
        clk1(1'b0, 1'b1, o);
        clk1(1'b0, 1'b1, o);
        oe_all = 1'b1;
    endtask
    task automatic shift(input int n, input logic [31:0] din, input logic last,
                         output logic [31:0] dout);
        logic o;
        dout = '0;
        for (int i = 0; i < n; i++)
        begin
            clk1(last && i == n - 1, din[i], o);
            dout[i] = o;
            oe_all = oe_all & line.oe;
        end
    endtask
    // from exit1 into pause, or from pause back into shift
    task automatic pause(input logic resume);
        logic o;
        clk1(resume, 1'b1, o);
        if (resume)
            clk1(1'b0, 1'b1, o);
    endtask
    task automatic leave();
        logic o;
        clk1(1'b1, 1'b1, o);
        clk1(1'b0, 1'b1, o);
    endtask
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        goto_shift(ir);
        shift(n, din, 1'b1, dout);
        leave();
    endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); end end
module testbench;
    import jtap_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic trst_b = 1'b0;
    logic core_tdo;
    logic usr_ready;
    logic drain = 1'b0;
    logic [BSW_DEF-1:0] bs_in;
    logic [BSW_DEF-1:0] bs_out;
    logic [BSW_DEF-1:0] bs_keep;
    logic [DW_DEF-1:0] usr_data;
    logic [DW_DEF-1:0] exp_w;
    logic usr_valid, core_sel, ext_mode, int_mode;
    jtap_pin_t pins;
    jtap_tdo_t tdo;
    logic [31:0] got, got2, d, pat;
    logic [IRW-1:0] byp [10] = '{I_BYPASS, 4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD,
                                 I_EXTEST, I_INTEST};
    logic [IRW-1:0] core_ir [3] = '{I_ABORT, I_DPACC, I_APACC};
    logic [DW_DEF-1:0] exp_q [$];
    int err_count = 0;
    int n_tests = 0;

    always #10 ref_clk = ~ref_clk;

    jtap_tap u_jtap_tap (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .trst_b(trst_b),
        .pins_i(pins),
        .tdo_o(tdo),
        .core_tdo_i(core_tdo),
        .core_sel_o(core_sel),
        .bs_pad_i(bs_in),
        .bs_pad_o(bs_out),
        .ext_mode_o(ext_mode),
        .int_mode_o(int_mode),
        .usr_data_o(usr_data),
        .usr_valid_o(usr_valid),
        .usr_ready_i(usr_ready)
    );
    jtap_host u_jtap_host (
        .pins(pins),
        .line(tdo)
    );
    ////////////////////////////////////////////////////////////////
    // the reader stalls in a random pattern while draining
    always @(posedge ref_clk)
    begin
        #2;
        usr_ready = drain & pat[0];
        pat = {pat[0], pat[31:1]};
    end
    always @(posedge ref_clk)
    begin
        if (usr_valid === 1'b1 && usr_ready === 1'b1)
        begin
            exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            `CHK(usr_data, exp_w)
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic dr(input int n, input logic [31:0] din);
        u_jtap_host.scan(1'b0, n, din, got);
        tick(4);
        `CHK(u_jtap_host.oe_all, 1'b1)
        `CHK(tdo.oe, 1'b0)
    endtask
    task automatic ir_load(input logic [IRW-1:0] code);
        u_jtap_host.scan(1'b1, IRW, 32'(code), got);
        tick(4);
        `CHK(got[IRW-1:0], IR_CAPT)
    endtask
    task automatic read_id();
        dr(IDW, 32'h0000_0000);
        `CHK(got, ID_DEF)
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #1_000_000;
        err_count++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'h0000_3e39));
        pat = ($urandom() | 32'h0000_0001) & 32'hFFFF_FFFD;
        d = $urandom();
        bs_in = d[BSW_DEF-1:0];
        core_tdo = d[BSW_DEF];
        usr_ready = 1'b0;
        tick(20);
        rst_b = 1'b1;
        trst_b = 1'b1;
        tick(6);
        `CHK(tdo.oe, 1'b0)
        u_jtap_host.to_idle(0);
        read_id();
        d = $urandom();
        bs_in = d[BSW_DEF-1:0];
        ir_load(I_SAMPLE);
        d = $urandom();
        dr(BSW_DEF, d);
        `CHK(got[BSW_DEF-1:0], bs_in)
        `CHK(bs_out, d[BSW_DEF-1:0])
        // halfway pause with the test clock stopped; the chain must resume intact
        d = $urandom();
        u_jtap_host.goto_shift(1'b0);
        u_jtap_host.shift(4, d, 1'b1, got);
        u_jtap_host.pause(1'b0);
        tick(4);
        bs_keep = bs_out;
        `CHK(tdo.oe, 1'b0)
        tick(200);
        `CHK(bs_out, bs_keep)
        u_jtap_host.pause(1'b1);
        u_jtap_host.shift(BSW_DEF - 4, d >> 4, 1'b1, got2);
        u_jtap_host.leave();
        tick(4);
        `CHK({got2[3:0], got[3:0]}, bs_in)
        `CHK(bs_out, d[BSW_DEF-1:0])
        bs_keep = bs_out;
        foreach (byp[i])
        begin
            ir_load(byp[i]);
            d = $urandom();
            dr(9, d);
            `CHK(got[8:0], {d[7:0], BYP_CAPT})
            `CHK(core_sel, 1'b0)
            `CHK(ext_mode, byp[i] == I_EXTEST)
            `CHK(int_mode, byp[i] == I_INTEST)
            `CHK(bs_out, bs_keep)
        end
        foreach (core_ir[i])
        begin
            ir_load(core_ir[i]);
            core_tdo = d[0] ^ i[0];
            dr(8, 32'h0000_0000);
            `CHK(core_sel, 1'b1)
            `CHK(got[7:0], {8{core_tdo}})
        end
        // test reset in mid-shift
        ir_load(I_SAMPLE);
        u_jtap_host.goto_shift(1'b0);
        u_jtap_host.shift(3, 32'h0000_0000, 1'b0, got);
        `CHK(tdo.oe, 1'b1)
        trst_b = 1'b0;
        tick(2);
        `CHK(tdo.oe, 1'b0)
        trst_b = 1'b1;
        tick(6);
        u_jtap_host.to_idle(0);
        read_id();
        ir_load(I_USER);
        u_jtap_host.goto_shift(1'b1);
        u_jtap_host.shift(2, 32'h0000_0000, 1'b0, got);
        u_jtap_host.to_idle(5);
        read_id();
        // fill past the top, the last word must be refused
        ir_load(I_USER);
        for (int k = 0; k <= FIFO_DEPTH; k++)
        begin
            d = $urandom();
            dr(DW_DEF, d);
            `CHK(got[0], k < FIFO_DEPTH)
            if (k < FIFO_DEPTH)
                exp_q.push_back(d[DW_DEF-1:0]);
        end
        `CHK(usr_valid, 1'b1)
        drain = 1'b1;
        for (int i = 0; i < 2000 && exp_q.size() > 0; i++)
            tick(1);
        tick(3);
        `CHK(exp_q.size(), 0)
        `CHK(usr_valid, 1'b0)
        // power-on reset in mid-shift clears the boundary outputs as well
        ir_load(I_SAMPLE);
        u_jtap_host.goto_shift(1'b1);
        u_jtap_host.shift(2, 32'h0000_0000, 1'b0, got);
        `CHK(tdo.oe, 1'b1)
        rst_b = 1'b0;
        tick(2);
        `CHK(tdo.oe, 1'b0)
        `CHK(bs_out, {BSW_DEF{1'b0}})
        rst_b = 1'b1;
        tick(6);
        u_jtap_host.to_idle(0);
        read_id();
        `CHK(u_jtap_host.edge_err, 0)
        conclude();
    end
endmodule
